// file: core/secure_remap_access_unit.sv
/*
  Secure remap access unit: configuration registers, unlock handling,
  channel enables, sticky status and the remapping master port.
  Assumes one-cycle request pulses on the configuration and channel ports,
  and a master slave that answers each held request with one done pulse.
*/
// How it works
// - Control write with setup-exit one leaves setup mode; zero does nothing.
// - Control write with setup-enter one enters setup mode; zero does nothing.
// - Control write with disable one disables the unit; zero does nothing.
// - Control write with enable one enables the unit; zero does nothing.
// - Configuration bit 16 turns open mode on or off as written.
// - Unlocked channel stays open for the cycle count or one access.
// - Unlock takes effect only when its key equals the configured key.
// - High enable bit n enables channel n+32; bit 31 unused.
// - Low enable bit n enables channel n.
// - Idle bit is one after reset, low while a remapped access runs.
// - Setup status bit shows whether the unit is in setup mode.
// - Enabled status bit shows whether the unit is enabled.
// - Remap target written in setup outside 0xFFFC..0xFFFF upper sets target error.
// - Bus error on a master transfer sets the master error flag.
// - Unlock write while any error flag is set is aborted, sets refused.
// - Unlock write with a wrong key sets the bad key flag.
// - Reading the unlock port sets the unlock read flag.
// - Access to a locked or disabled channel sets the access failed flag.
// - One access through an unlocked channel sets the succeeded flag.
// - Event flags stay set until a one is written to interrupt clear.
// - Window lapsing without an access sets the expired flag.
// - All flags except succeeded block unlocking.
// - Interrupt request is high while a set flag has its mask bit set.
`timescale 1ns/1ps
module secure_remap_access_unit
  import secure_access_pkg::*;
#(
  parameter int unsigned NUM_CH = MAX_CH
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire cfg_req_t      cfgReq,
  output logic [DATA_W-1:0]  cfgRdata,
  input  wire ch_req_t       chReq,
  output ch_rsp_t            chRsp,
  output mst_req_t           mstReq,
  input  wire mst_rsp_t      mstRsp,
  output logic               irq
);

  // Busy while a remapped transfer waits on the slave
  typedef enum logic [0:0] {
    S_READY,
    S_MASTER
  } state_t;

  state_t             state_q;
  logic               enabled_q;
  logic               setup_q;
  logic               open_q;
  logic               berrEn_q;
  logic [CYC_W-1:0]   cycles_q;
  logic [7:0]         key_q;
  logic [30:0]        cenHigh_q;
  logic [31:0]        cenLow_q;
  logic [FLAG_W-1:0]  flags_q;
  logic [FLAG_W-1:0]  flags_d;
  logic [FLAG_W-1:0]  mask_q;
  logic               idle_q;
  logic [5:0]         unlockCh_q;
  logic [DATA_W-1:0]  target_q [NUM_CH];
  logic [62:0]        chanEnable;

  logic               take;
  logic               isUnlock;
  logic [5:0]         idx;
  logic               setupAcc;
  logic               unlockWr;
  logic               unlockRd;
  logic               chanAcc;
  logic               allowed;
  logic               goMaster;
  logic               failAcc;
  logic               refused;
  logic               badKey;
  logic               unlockOk;
  logic               tgtErr;
  logic               winActive;
  logic               winExpired;
  logic [FLAG_W-1:0]  flagSet;
  logic [FLAG_W-1:0]  flagClr;

  logic               cfgWr;
  logic               ctlWr;
  logic               confWr;
  logic               cenHighWr;
  logic               cenLowWr;
  logic               maskSetWr;
  logic               maskClrWr;
  logic               flagClrWr;
  logic [63:0]        chanOpen;

  // Register decode of the configuration port
  always_comb begin
    cfgWr     = cfgReq.wr;
    ctlWr     = cfgWr && (cfgReq.addr == OFS_CONTROL);
    confWr    = cfgWr && (cfgReq.addr == OFS_CONFIG);
    cenHighWr = cfgWr && (cfgReq.addr == OFS_CEN_HIGH);
    cenLowWr  = cfgWr && (cfgReq.addr == OFS_CEN_LOW);
    maskSetWr = cfgWr && (cfgReq.addr == OFS_IRQ_EN);
    maskClrWr = cfgWr && (cfgReq.addr == OFS_IRQ_DIS);
    flagClrWr = cfgWr && (cfgReq.addr == OFS_IRQ_CLEAR);
  end

  // Channel n+32 sits in the high register
  assign chanEnable = {cenHigh_q, cenLow_q};

  // Per-channel permission; channels past NUM_CH never open
  for (genvar n = 0; n < 64; n++) begin : g_chan
    if (n < NUM_CH) begin : g_real
      assign chanOpen[n] = chanEnable[n]
                           && (open_q || (winActive && unlockCh_q == 6'(n)));
    end else begin : g_none
      assign chanOpen[n] = 1'b0;
    end
  end

  always_comb begin
    take     = (state_q == S_READY) && chReq.valid;
    isUnlock = (chReq.addr == OFS_UNLOCK);
    idx      = chReq.addr[7:2];
    setupAcc = take && setup_q && !isUnlock;
    unlockRd = take && isUnlock && !chReq.write;
    unlockWr = take && !setup_q && isUnlock && chReq.write;
    chanAcc  = take && !setup_q && !isUnlock;
    allowed  = enabled_q && chanOpen[idx];
    goMaster = chanAcc && allowed;
    failAcc  = chanAcc && !allowed;
    // Refusal is judged before the key, so a refused write never flags a bad key
    refused  = unlockWr && |(flags_q & ERROR_MASK);
    badKey   = unlockWr && !refused
               && (chReq.wdata[UNL_KEY_LSB +: 8] != key_q);
    unlockOk = unlockWr && !refused && !badKey;
    tgtErr   = setupAcc && chReq.write
               && (chReq.wdata[31:16] < TGT_HI_MIN);
  end

  // Any channel access, allowed or not, closes an open window
  unlock_window #(
    .CNT_W (CYC_W)
  ) u_window (
    .clk     (clk),
    .rst     (rst),
    .start   (unlockOk),
    .cycles  (cycles_q),
    .consume (chanAcc),
    .active  (winActive),
    .expired (winExpired)
  );

  // Unit control and configuration
  // Disable wins over enable, setup exit over enter
  always_ff @(posedge clk) begin
    if (rst) begin
      enabled_q <= 1'b0;
      setup_q   <= 1'b0;
      berrEn_q  <= 1'b0;
    end else if (ctlWr) begin
      if (cfgReq.wdata[CTL_DIS]) begin
        enabled_q <= 1'b0;
      end else if (cfgReq.wdata[CTL_EN]) begin
        enabled_q <= 1'b1;
      end
      if (cfgReq.wdata[CTL_SETUP_EXIT]) begin
        setup_q <= 1'b0;
      end else if (cfgReq.wdata[CTL_SEN]) begin
        setup_q <= 1'b1;
      end
      if (cfgReq.wdata[CTL_BERRDIS]) begin
        berrEn_q <= 1'b0;
      end else if (cfgReq.wdata[CTL_BERREN]) begin
        berrEn_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      open_q   <= 1'b0;
      cycles_q <= '0;
      key_q    <= '0;
    end else if (confWr) begin
      open_q   <= cfgReq.wdata[CFG_OPEN];
      cycles_q <= cfgReq.wdata[CFG_CYC_LSB +: CYC_W];
      key_q    <= cfgReq.wdata[CFG_KEY_LSB +: 8];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cenHigh_q <= '0;
      cenLow_q  <= '0;
    end else if (cfgWr) begin
      // Bit 31 of the high register is not stored and reads back as zero
      if (cenHighWr) begin
        cenHigh_q <= cfgReq.wdata[30:0];
      end
      if (cenLowWr) begin
        cenLow_q <= cfgReq.wdata;
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q <= '0;
    end else if (maskSetWr) begin
      mask_q <= mask_q | cfgReq.wdata[FLAG_W-1:0];
    end else if (maskClrWr) begin
      mask_q <= mask_q & ~cfgReq.wdata[FLAG_W-1:0];
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle
  always_comb begin
    flagSet               = '0;
    flagSet[ST_EXPIRED]   = winExpired && !chanAcc;
    flagSet[ST_SUCCEEDED] = goMaster;
    flagSet[ST_FAILED]    = failAcc;
    flagSet[ST_UNL_READ]  = unlockRd;
    flagSet[ST_BAD_KEY]   = badKey;
    flagSet[ST_REFUSED]   = refused;
    flagSet[ST_MST_ERR]   = (state_q == S_MASTER) && mstRsp.done && mstRsp.err;
    flagSet[ST_TGT_ERR]   = tgtErr;
    flagClr = '0;
    if (flagClrWr) begin
      flagClr = cfgReq.wdata[FLAG_W-1:0];
    end
    flags_d = (flags_q & ~flagClr) | flagSet;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_q & mask_q);
    end
  end

  // Unlocked channel number
  always_ff @(posedge clk) begin
    if (rst) begin
      unlockCh_q <= '0;
    end else if (unlockOk) begin
      unlockCh_q <= chReq.wdata[UNL_CH_LSB +: 6];
    end
  end

  // Remap target store, written and read in setup mode
  // Values are kept as written, legal or not
  always_ff @(posedge clk) begin
    if (setupAcc && chReq.write && 32'(idx) < NUM_CH) begin
      target_q[idx] <= chReq.wdata;
    end
  end

  // Idle drops for the whole remapped transfer
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_q <= 1'b1;
    end else if (goMaster) begin
      idle_q <= 1'b0;
    end else if ((state_q == S_MASTER) && mstRsp.done) begin
      idle_q <= 1'b1;
    end
  end

  // Channel access sequencing and master port
  // Bus error answers only when enabled; otherwise every access ends cleanly
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= S_READY;
      chRsp   <= '0;
      mstReq  <= '0;
    end else begin
      chRsp.ack <= 1'b0;
      chRsp.err <= 1'b0;
      case (state_q)
        S_READY: begin
          if (goMaster) begin
            state_q       <= S_MASTER;
            mstReq.req    <= 1'b1;
            mstReq.write  <= chReq.write;
            mstReq.addr   <= target_q[idx];
            mstReq.wdata  <= chReq.wdata;
          end else if (take) begin
            chRsp.ack   <= 1'b1;
            chRsp.err   <= berrEn_q && (unlockRd || failAcc);
            chRsp.rdata <= '0;
            if (setupAcc && !chReq.write && 32'(idx) < NUM_CH) begin
              chRsp.rdata <= target_q[idx];
            end
          end
        end
        S_MASTER: begin
          if (mstRsp.done) begin
            state_q     <= S_READY;
            mstReq.req  <= 1'b0;
            chRsp.ack   <= 1'b1;
            chRsp.err   <= berrEn_q && mstRsp.err;
            chRsp.rdata <= mstRsp.rdata;
          end
        end
        default: begin
          state_q    <= S_READY;
          mstReq.req <= 1'b0;
        end
      endcase
    end
  end

  // Configuration read data, valid the cycle after the read pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      cfgRdata <= '0;
    end else if (cfgReq.rd) begin
      case (cfgReq.addr)
        OFS_CEN_HIGH:  cfgRdata <= {1'b0, cenHigh_q};
        OFS_CEN_LOW:   cfgRdata <= cenLow_q;
        OFS_STATUS:    cfgRdata <= {21'h0, idle_q, setup_q, enabled_q, flags_q};
        OFS_IRQ_MASK:  cfgRdata <= {24'h0, mask_q};
        OFS_PARAMETER: cfgRdata <= NUM_CH;
        default:       cfgRdata <= '0;
      endcase
    end
  end

endmodule

// file: core/secure_access_pkg.sv
/*
  Shared constants and carrier types of the secure remap access unit.
  Assumes a single 125 MHz clock and 32-bit register data on both ports.
*/
package secure_access_pkg;

  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned CYC_W         = 8;
  localparam int unsigned FLAG_W        = 8;
  localparam int unsigned MAX_CH        = 63;

  // Configuration port offsets
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_CONFIG     = 8'h04;
  localparam logic [7:0] OFS_CEN_HIGH   = 8'h08;
  localparam logic [7:0] OFS_CEN_LOW    = 8'h0C;
  localparam logic [7:0] OFS_STATUS     = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN     = 8'h14;
  localparam logic [7:0] OFS_IRQ_DIS    = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h1C;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h20;
  localparam logic [7:0] OFS_PARAMETER  = 8'h24;

  // Channel port offset of the unlock port
  localparam logic [7:0] OFS_UNLOCK     = 8'hFC;

  // Control bits
  localparam int unsigned CTL_EN        = 0;
  localparam int unsigned CTL_DIS       = 1;
  localparam int unsigned CTL_SEN       = 2;
  localparam int unsigned CTL_SETUP_EXIT      = 3;
  localparam int unsigned CTL_BERREN    = 4;
  localparam int unsigned CTL_BERRDIS   = 5;

  // Configuration fields
  localparam int unsigned CFG_OPEN      = 16;
  localparam int unsigned CFG_CYC_LSB   = 8;
  localparam int unsigned CFG_KEY_LSB   = 0;

  // Unlock port fields
  localparam int unsigned UNL_KEY_LSB   = 8;
  localparam int unsigned UNL_CH_LSB    = 0;

  // Status bits
  localparam int unsigned ST_EXPIRED    = 0;
  localparam int unsigned ST_SUCCEEDED  = 1;
  localparam int unsigned ST_FAILED     = 2;
  localparam int unsigned ST_UNL_READ   = 3;
  localparam int unsigned ST_BAD_KEY    = 4;
  localparam int unsigned ST_REFUSED    = 5;
  localparam int unsigned ST_MST_ERR    = 6;
  localparam int unsigned ST_TGT_ERR    = 7;
  localparam int unsigned ST_ENABLED    = 8;
  localparam int unsigned ST_SETUP      = 9;
  localparam int unsigned ST_IDLE       = 10;

  localparam logic [31:0] STATUS_RESET  = 32'h0000_0400;
  localparam logic [7:0]  ERROR_MASK    = 8'hFD;
  localparam logic [15:0] TGT_HI_MIN    = 16'hFFFC;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ch_req_t;

  typedef struct packed {
    logic              ack;
    logic              err;
    logic [DATA_W-1:0] rdata;
  } ch_rsp_t;

  typedef struct packed {
    logic              req;
    logic              write;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mst_req_t;

  typedef struct packed {
    logic              done;
    logic              err;
    logic [DATA_W-1:0] rdata;
  } mst_rsp_t;

endpackage

// file: core/unlock_window.sv
/*
  Unlock window timer: holds a channel open for a programmed number of cycles.
  Assumes start and consume are one-cycle pulses on the unit clock.
*/
`timescale 1ns/1ps
module unlock_window
  import secure_access_pkg::*;
#(
  parameter int unsigned CNT_W = CYC_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] cycles,
  input  wire logic             consume,
  output logic                  active,
  output logic                  expired
);

  logic [CNT_W-1:0] count_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= '0;
      active  <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        count_q <= cycles;
        active  <= (cycles != '0);
        expired <= (cycles == '0);
      end else if (active) begin
        if (consume) begin
          active <= 1'b0;
        end else if (count_q <= CNT_W'(1)) begin
          active  <= 1'b0;
          expired <= 1'b1;
        end else begin
          count_q <= count_q - CNT_W'(1);
        end
      end
    end
  end

endmodule

// file: verif/sec_slave_model.sv
/*
  Slave on the master port: answers each held request after a short or long wait.
  Assumes the unit holds its request steady until the done pulse.
*/
`timescale 1ns/1ps
module sec_slave_model
  import secure_access_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire mst_req_t mstReq,
  input  wire logic     slow,
  input  wire logic     errOn,
  output mst_rsp_t      mstRsp,
  output logic [31:0]   lastAddr,
  output logic          lastWrite,
  output logic [31:0]   lastWdata
);
  logic [2:0] waitQ;
  logic       hit;

  assign hit = mstReq.req && !mstRsp.done && (waitQ == (slow ? 3'h4 : 3'h0));

  always_ff @(posedge clk) begin
    if (rst || !mstReq.req || mstRsp.done) begin
      waitQ <= 3'h0;
    end else begin
      waitQ <= waitQ + 3'h1;
    end
  end

  // Data outside a done pulse keeps toggling so stale values never match
  always_ff @(posedge clk) begin
    if (rst) begin
      mstRsp <= '0;
    end else begin
      mstRsp.done  <= hit;
      mstRsp.err   <= hit && errOn;
      mstRsp.rdata <= hit ? ~mstReq.addr : ~mstRsp.rdata;
    end
    if (hit) begin
      lastAddr  <= mstReq.addr;
      lastWrite <= mstReq.write;
      lastWdata <= mstReq.wdata;
    end
  end
endmodule

// file: verif/secure_remap_access_unit_chk.sv
/*
  Port checker of the secure remap access unit.
  Assumes it is bound into every instance of the unit.
*/
`timescale 1ns/1ps
module secure_remap_access_unit_chk
  import secure_access_pkg::*;
#(
  parameter int unsigned NUM_CH = MAX_CH
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire cfg_req_t          cfgReq,
  input wire logic [DATA_W-1:0] cfgRdata,
  input wire ch_req_t           chReq,
  input wire ch_rsp_t           chRsp,
  input wire mst_req_t          mstReq,
  input wire mst_rsp_t          mstRsp,
  input wire logic              irq
);
  logic        enQ;
  logic        setupQ;
  logic [31:0] cenHQ;
  logic [31:0] cenLQ;
  logic        ctlWr;
  logic        stRd;

  assign ctlWr = cfgReq.wr && cfgReq.addr == OFS_CONTROL;
  assign stRd  = cfgReq.rd && cfgReq.addr == OFS_STATUS;

  always_ff @(posedge clk) begin
    if (rst) begin
      enQ <= 1'h0;
    end else if (ctlWr && (cfgReq.wdata[CTL_EN] || cfgReq.wdata[CTL_DIS])) begin
      enQ <= !cfgReq.wdata[CTL_DIS];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      setupQ <= 1'h0;
    end else if (ctlWr && (cfgReq.wdata[CTL_SEN] || cfgReq.wdata[CTL_SETUP_EXIT])) begin
      setupQ <= !cfgReq.wdata[CTL_SETUP_EXIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cenHQ <= 32'h0000_0000;
      cenLQ <= 32'h0000_0000;
    end else if (cfgReq.wr) begin
      if (cfgReq.addr == OFS_CEN_HIGH) begin
        cenHQ <= cfgReq.wdata;
      end
      if (cfgReq.addr == OFS_CEN_LOW) begin
        cenLQ <= cfgReq.wdata;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_done;
    mstReq.req && mstRsp.done;
  endsequence
  sequence s_unlock;
    chReq.valid && chReq.write && chReq.addr == OFS_UNLOCK && !mstReq.req;
  endsequence
  sequence s_mute;
    chReq.valid && !mstReq.req && (!enQ || setupQ);
  endsequence

  a_status_enabled: assert property (stRd |=> cfgRdata[ST_ENABLED] == $past(enQ))
    else $error("enabled status bit wrong");
  a_status_setup: assert property (stRd |=> cfgRdata[ST_SETUP] == $past(setupQ))
    else $error("setup status bit wrong");
  a_idle_status: assert property (stRd |=> cfgRdata[ST_IDLE] == !$past(mstReq.req))
    else $error("idle status bit wrong");
  a_mute_channel: assert property (s_mute |=> !mstReq.req [*2])
    else $error("master transfer from a muted channel");
  a_unlock_local: assert property (s_unlock |=> chRsp.ack && !mstReq.req)
    else $error("unlock write not answered locally");
  a_master_hold: assert property (mstReq.req && !mstRsp.done |=> mstReq.req && $stable(mstReq.addr))
    else $error("master request dropped early");
  a_done_ack: assert property (s_done |=> chRsp.ack && !mstReq.req)
    else $error("no ack after master done");
  a_cen_high: assert property (cfgReq.rd && cfgReq.addr == OFS_CEN_HIGH |=>
    cfgRdata == ($past(cenHQ) & 32'h7FFF_FFFF)) else $error("high enable readback wrong");
  a_cen_low: assert property (cfgReq.rd && cfgReq.addr == OFS_CEN_LOW |=>
    cfgRdata == $past(cenLQ)) else $error("low enable readback wrong");
  a_irq_off: assert property (cfgReq.wr && cfgReq.addr == OFS_IRQ_DIS &&
    cfgReq.wdata[7:0] == 8'hFF |=> ##1 !irq) else $error("irq with all masks off");
endmodule

bind secure_remap_access_unit secure_remap_access_unit_chk #(.NUM_CH(NUM_CH)) chk (
  .clk(clk), .rst(rst), .cfgReq(cfgReq), .cfgRdata(cfgRdata), .chReq(chReq),
  .chRsp(chRsp), .mstReq(mstReq), .mstRsp(mstRsp), .irq(irq));

// file: verif/tb.sv
/*
  Self-checking bench of the secure remap access unit with a slave model.
  Assumes the package, design and checker sources are compiled first.
*/
`timescale 1ns/1ps
module tb
  import secure_access_pkg::*;
;
  localparam logic [31:0] ON    = 32'h0000_0500;
  localparam logic [31:0] TGT0  = 32'hFFFC_0100;
  localparam logic [31:0] TGT32 = 32'hFFFF_0020;
  typedef struct {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] ex;
  } row_t;
  row_t rows [10] = '{
    '{8'h00, 32'h0000_0000, 8'h10, 32'h0000_0400},
    '{8'h00, 32'h0000_0001, 8'h10, 32'h0000_0500},
    '{8'h00, 32'h0000_0004, 8'h10, 32'h0000_0700},
    '{8'h00, 32'h0000_0000, 8'h10, 32'h0000_0700},
    '{8'h00, 32'h0000_0008, 8'h10, 32'h0000_0500},
    '{8'h00, 32'h0000_0003, 8'h10, 32'h0000_0400},
    '{8'h08, 32'hFFFF_FFFF, 8'h08, 32'h7FFF_FFFF},
    '{8'h0C, 32'hFFFF_FFFF, 8'h0C, 32'hFFFF_FFFF},
    '{8'h14, 32'h0000_00FF, 8'h1C, 32'h0000_00FF},
    '{8'h18, 32'h0000_00FF, 8'h1C, 32'h0000_0000}};
  logic        clk;
  logic        rst;
  logic        slow;
  logic        errOn;
  logic        irq;
  logic [31:0] cfgRdata;
  logic [31:0] lastAddr;
  logic [31:0] rdLast;
  logic        errLast;
  logic        lastWrite;
  logic [31:0] lastWdata;
  cfg_req_t    cfgReq;
  ch_req_t     chReq;
  ch_rsp_t     chRsp;
  mst_req_t    mstReq;
  mst_rsp_t    mstRsp;
  int          nErrors = 0;
  int          checkCount = 0;

  secure_remap_access_unit uut (.clk, .rst, .cfgReq, .cfgRdata, .chReq, .chRsp,
    .mstReq, .mstRsp, .irq);
  sec_slave_model mdl (.clk, .rst, .mstReq, .slow, .errOn, .mstRsp, .lastAddr,
    .lastWrite, .lastWdata);

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic results();
    if (nErrors == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cfgWr(input logic [7:0] a, input logic [31:0] d);
    cfgReq = '{1'h1, 1'h0, a, d};
    tick();
    cfgReq = '0;
    tick();
  endtask
  task automatic cfgRd(input logic [7:0] a, input logic [31:0] e);
    cfgReq = '{1'h0, 1'h1, a, 32'h0000_0000};
    tick();
    cfgReq = '0;
    check(cfgRdata, e);
    tick();
  endtask
  task automatic chWait();
    for (int i = 0; i < 20 && chRsp.ack !== 1'h1; i++) begin
      tick();
    end
    if (chRsp.ack !== 1'h1) begin
      nErrors++;
      $display("unexpected at %0t: no channel ack", $time);
      results();
    end else begin
      rdLast = chRsp.rdata;
      errLast = chRsp.err;
      tick();
    end
  endtask
  task automatic chAcc(input logic w, input logic [7:0] a, input logic [31:0] d);
    chReq = '{1'h1, w, a, d};
    tick();
    chReq = '0;
    chWait();
  endtask
  task automatic unl(input logic [7:0] k, input logic [5:0] n);
    chAcc(1'h1, OFS_UNLOCK, {16'h0000, k, 2'h0, n});
  endtask
  task automatic flags(input logic [31:0] e);
    cfgRd(OFS_STATUS, ON | e);
    cfgWr(OFS_IRQ_CLEAR, 32'h0000_00FF);
    cfgRd(OFS_STATUS, ON);
  endtask

  initial begin
    cfgReq = '0;
    chReq = '0;
    slow = 1'h0;
    errOn = 1'h0;
    rst = 1'h1;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'h0;
    foreach (rows[i]) begin
      cfgWr(rows[i].wa, rows[i].wd);
      cfgRd(rows[i].ra, rows[i].ex);
    end
    // Load targets in setup mode, one of them illegal
    cfgWr(OFS_CONTROL, 32'h0000_0005);
    chAcc(1'h1, 8'h00, TGT0);
    chAcc(1'h1, 8'h80, TGT32);
    chAcc(1'h1, 8'h04, 32'h1234_0000);
    chAcc(1'h0, 8'h00, 32'h0000_0000);
    check(rdLast, TGT0);
    cfgWr(OFS_CONTROL, 32'h0000_0008);
    cfgWr(OFS_CONFIG, 32'h0000_045A);
    cfgWr(OFS_CEN_LOW, 32'h0000_0001);
    cfgWr(OFS_CEN_HIGH, 32'h0000_0001);
    unl(8'h5A, 6'h00);
    flags(32'h0000_00A0);
    unl(8'h11, 6'h00);
    flags(32'h0000_0010);
    cfgWr(OFS_IRQ_EN, 32'h0000_0004);
    chAcc(1'h0, 8'h00, 32'h0000_0000);
    tick();
    check({31'h0000_0000, irq}, 32'h0000_0001);
    flags(32'h0000_0004);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    cfgWr(OFS_CONTROL, 32'h0000_0010);
    chAcc(1'h0, OFS_UNLOCK, 32'h0000_0000);
    check({31'h0000_0000, errLast}, 32'h0000_0001);
    flags(32'h0000_0008);
    // Slow remapped read, status looked at while it runs
    unl(8'h5A, 6'h00);
    slow = 1'h1;
    chReq = '{1'h1, 1'h0, 8'h00, 32'h0000_0000};
    tick();
    chReq = '0;
    cfgRd(OFS_STATUS, 32'h0000_0102);
    chWait();
    check(rdLast, ~TGT0);
    check(lastAddr, TGT0);
    check({30'h0000_0000, errLast, lastWrite}, 32'h0000_0000);
    slow = 1'h0;
    unl(8'h5A, 6'h00);
    chAcc(1'h1, 8'h00, 32'h0000_ABCD);
    check(lastWdata, 32'h0000_ABCD);
    check({31'h0000_0000, lastWrite}, 32'h0000_0001);
    chAcc(1'h0, 8'h00, 32'h0000_0000);
    flags(32'h0000_0006);
    unl(8'h5A, 6'h00);
    repeat (8) tick();
    chAcc(1'h0, 8'h00, 32'h0000_0000);
    flags(32'h0000_0005);
    errOn = 1'h1;
    unl(8'h5A, 6'h00);
    chAcc(1'h0, 8'h00, 32'h0000_0000);
    check({31'h0000_0000, errLast}, 32'h0000_0001);
    errOn = 1'h0;
    unl(8'h5A, 6'h00);
    flags(32'h0000_0062);
    unl(8'h5A, 6'h20);
    chAcc(1'h1, 8'h80, 32'h0000_0077);
    check(lastAddr, TGT32);
    check(lastWdata, 32'h0000_0077);
    flags(32'h0000_0002);
    unl(8'h5A, 6'h02);
    chAcc(1'h0, 8'h08, 32'h0000_0000);
    flags(32'h0000_0004);
    cfgWr(OFS_CONFIG, 32'h0001_045A);
    chAcc(1'h0, 8'h00, 32'h0000_0000);
    flags(32'h0000_0002);
    cfgWr(OFS_CONFIG, 32'h0000_045A);
    chAcc(1'h0, 8'h00, 32'h0000_0000);
    flags(32'h0000_0004);
    // Reset in mid-run with the unit enabled, a flag and the whole mask set
    cfgWr(OFS_IRQ_EN, 32'h0000_00FF);
    chAcc(1'h0, OFS_UNLOCK, 32'h0000_0000);
    rst = 1'h1;
    repeat (2) tick();
    rst = 1'h0;
    cfgRd(OFS_STATUS, STATUS_RESET);
    cfgRd(OFS_CEN_LOW, 32'h0000_0000);
    cfgRd(OFS_IRQ_MASK, 32'h0000_0000);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    results();
  end
endmodule
